// >>> core/opt_consts.svh
`ifndef OPT_CONSTS_SVH
`define OPT_CONSTS_SVH

// Register addresses.
`define ADDR_SETUP 8'h0A
`define ADDR_RED_LVL 8'h0C
`define ADDR_IR_LVL 8'h0D
`define ADDR_GRNA_LVL 8'h0E
`define ADDR_GRNB_LVL 8'h0F
`define ADDR_SLOT_12 8'h11
`define ADDR_SLOT_34 8'h12
`define ADDR_HEAT_WHOLE 8'h1F
`define ADDR_HEAT_FRAC 8'h20
`define ADDR_HEAT_TRIG 8'h21
`define REG_RESET 8'h00

// Field positions.
`define RANGE_HI 6
`define RANGE_LO 5
`define RATE_HI 4
`define RATE_LO 2
`define PW_HI 1
`define PW_LO 0
`define ODD_SLOT_HI 2
`define ODD_SLOT_LO 0
`define EVEN_SLOT_HI 6
`define EVEN_SLOT_LO 4
`define SLOT_FIELD_MASK 8'h77
`define FRAC_MASK 8'h0F
`define TRIG_BIT 0

// Slot codes.
`define SLOT_OFF 3'h0
`define SLOT_RED 3'h1
`define SLOT_IR 3'h2
`define SLOT_GREEN 3'h3
`define SLOT_NONE 3'h4

// Clock and timing.
`define CLK_MHZ 10
`define PW_69_US 69
`define PW_118_US 118
`define PW_215_US 215
`define PW_411_US 411
`define PW_69_CYC (`PW_69_US * `CLK_MHZ)
`define PW_118_CYC (`PW_118_US * `CLK_MHZ)
`define PW_215_CYC (`PW_215_US * `CLK_MHZ)
`define PW_411_CYC (`PW_411_US * `CLK_MHZ)
`define PERIOD_50_US 20000
`define PERIOD_50_CYC (`PERIOD_50_US * `CLK_MHZ)
`define TEMP_CONV_US 29000
`define TEMP_CONV_CYC (`TEMP_CONV_US * `CLK_MHZ)

// Sample rates per code, and fastest code per pulse width.
`define SPS_REF 50
`define SPS_0 50
`define SPS_1 100
`define SPS_2 200
`define SPS_3 400
`define SPS_4 800
`define SPS_5 1000
`define SPS_6 1600
`define SPS_7 3200
`define MAX_RATE_PW0 3'h7
`define MAX_RATE_PW1 3'h6
`define MAX_RATE_PW2 3'h5
`define MAX_RATE_PW3 3'h4

// Converter resolution per pulse width code.
`define FULL_BITS 5'd18
`define RES_PW0 5'd15
`define RES_PW1 5'd16
`define RES_PW2 5'd17
`define RES_PW3 5'd18

`endif

// >>> core/opt_pkg.sv
package opt_pkg;

    // Drive levels of the four emitter outputs.
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] infrared;
        logic [7:0] greenA;
        logic [7:0] greenB;
    } led_drive_s;

    // One byte of the sample stream with its slot number.
    typedef struct packed {
        logic [7:0] data;
        logic [1:0] slot;
    } stream_byte_s;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SCAN,
        SEQ_PULSE,
        SEQ_PUSH
    } seq_state_e;

endpackage

// >>> core/optical_sample_config_temp.sv
// Contract
// - Range field picks full scale 2048 to 16384 nA at 18 bits.
// - Rate field picks 50 to 3200 samples per second, codes 0 to 7.
// - Each sample pulses and converts every active slot once.
// - Too fast a written rate stores the fastest rate the width allows.
// - Width field picks 69, 118, 215 or 411 us, shared by all emitters.
// - Converter resolution follows width: 15, 16, 17 or 18 bits.
// - Each 8-bit level sets drive current at 0.2 mA per step.
// - Multi-emitter mode splits a sample into up to four ordered slots.
// - Slot codes: off, red, infrared, green, none; 5 to 7 reserved.
// - Each active slot pushes three bytes; a sample holds all active slots.
// - A green slot drives with both green levels.
// - Whole part is 8-bit two's complement, one degree per bit.
// - Fraction field holds sixteenths of a degree in four bits.
// - Trigger bit starts one conversion and clears itself at the end.
// - Slot fields one and two at 0x11, three and four at 0x12.
// - Mode change leaves settings and stored data unchanged.
// - Finished conversion raises a temperature-ready flag.
`timescale 1ns/1ps
`include "opt_consts.svh"

module optical_sample_config_temp import opt_pkg::*; #(
    parameter int unsigned PERIOD_50_CYC = `PERIOD_50_CYC,
    parameter int unsigned PW_411_CYC = `PW_411_CYC,
    parameter int unsigned TEMP_CONV_CYC = `TEMP_CONV_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic acquireEnable,
    input wire logic multiLedMode,
    input wire logic [17:0] adcSample,
    input wire logic [11:0] tempSense,
    output logic [1:0] converterRange,
    output led_drive_s ledDrive,
    output logic byteValid,
    input wire logic byteReady,
    output stream_byte_s byteOut,
    output logic tempReady
);

    // ------------------------------------------------------------
    // Registers and next values
    // ------------------------------------------------------------
    logic [7:0] acqSetup;
    led_drive_s levels;
    logic [7:0] slotOneTwo;
    logic [7:0] slotThreeFour;
    logic [7:0] heatWhole;
    logic [7:0] heatFrac;
    logic tempBusy;
    logic [31:0] tempCnt;
    logic [7:0] next_acqSetup;
    led_drive_s next_levels;
    logic [7:0] next_slotOneTwo;
    logic [7:0] next_slotThreeFour;
    logic [7:0] next_heatWhole;
    logic [7:0] next_heatFrac;
    logic next_tempBusy;
    logic [31:0] next_tempCnt;
    logic [7:0] next_regRdata;
    logic next_tempReady;
    logic [2:0] reqRate;
    logic [1:0] reqPw;
    logic [2:0] maxRate;

    assign converterRange = acqSetup[`RANGE_HI:`RANGE_LO];

    // Fastest rate that a pulse width still fits into.
    always_comb begin
        reqRate = regWdata[`RATE_HI:`RATE_LO];
        reqPw = regWdata[`PW_HI:`PW_LO];
        unique case (reqPw)
            2'h0: maxRate = `MAX_RATE_PW0;
            2'h1: maxRate = `MAX_RATE_PW1;
            2'h2: maxRate = `MAX_RATE_PW2;
            2'h3: maxRate = `MAX_RATE_PW3;
        endcase
    end

    // ------------------------------------------------------------
    // Register writes and temperature conversion
    // ------------------------------------------------------------
    // A conversion that ends in the same cycle as a host write to the
    // result registers wins, so a fresh reading is never overwritten.
    always_comb begin
        next_acqSetup = acqSetup;
        next_levels = levels;
        next_slotOneTwo = slotOneTwo;
        next_slotThreeFour = slotThreeFour;
        next_heatWhole = heatWhole;
        next_heatFrac = heatFrac;
        next_tempBusy = tempBusy;
        next_tempCnt = tempCnt;
        next_tempReady = 1'b0;
        if (regWrite) begin
            unique case (regAddr)
                `ADDR_SETUP: begin
                    next_acqSetup = regWdata;
                    if (reqRate > maxRate) begin
                        next_acqSetup[`RATE_HI:`RATE_LO] = maxRate;
                    end
                end
                `ADDR_RED_LVL: next_levels.red = regWdata;
                `ADDR_IR_LVL: next_levels.infrared = regWdata;
                `ADDR_GRNA_LVL: next_levels.greenA = regWdata;
                `ADDR_GRNB_LVL: next_levels.greenB = regWdata;
                `ADDR_SLOT_12: begin
                    next_slotOneTwo = regWdata & `SLOT_FIELD_MASK;
                end
                `ADDR_SLOT_34: begin
                    next_slotThreeFour = regWdata & `SLOT_FIELD_MASK;
                end
                `ADDR_HEAT_WHOLE: next_heatWhole = regWdata;
                `ADDR_HEAT_FRAC: next_heatFrac = regWdata & `FRAC_MASK;
                `ADDR_HEAT_TRIG: begin
                    if (regWdata[`TRIG_BIT] && !tempBusy) begin
                        next_tempBusy = 1'b1;
                        next_tempCnt = TEMP_CONV_CYC - 1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (tempBusy) begin
            if (tempCnt == '0) begin
                next_tempBusy = 1'b0;
                next_heatWhole = tempSense[11:4];
                next_heatFrac = {4'h0, tempSense[3:0]};
                next_tempReady = 1'b1;
            end else begin
                next_tempCnt = tempCnt - 32'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_comb begin
        next_regRdata = regRdata;
        if (regRead) begin
            unique case (regAddr)
                `ADDR_SETUP: next_regRdata = acqSetup;
                `ADDR_RED_LVL: next_regRdata = levels.red;
                `ADDR_IR_LVL: next_regRdata = levels.infrared;
                `ADDR_GRNA_LVL: next_regRdata = levels.greenA;
                `ADDR_GRNB_LVL: next_regRdata = levels.greenB;
                `ADDR_SLOT_12: next_regRdata = slotOneTwo;
                `ADDR_SLOT_34: next_regRdata = slotThreeFour;
                `ADDR_HEAT_WHOLE: next_regRdata = heatWhole;
                `ADDR_HEAT_FRAC: next_regRdata = heatFrac;
                `ADDR_HEAT_TRIG: next_regRdata = {7'h00, tempBusy};
                default: next_regRdata = `REG_RESET;
            endcase
        end
    end

    // Mode is only an input to the sequencer; no register is touched by
    // it, so switching modes keeps all settings and results.
    // Mode keeps settings.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acqSetup <= `REG_RESET;
            levels <= '0;
            slotOneTwo <= `REG_RESET;
            slotThreeFour <= `REG_RESET;
            heatWhole <= `REG_RESET;
            heatFrac <= `REG_RESET;
            tempBusy <= 1'b0;
            tempCnt <= '0;
            regRdata <= `REG_RESET;
            tempReady <= 1'b0;
        end else begin
            acqSetup <= next_acqSetup;
            levels <= next_levels;
            slotOneTwo <= next_slotOneTwo;
            slotThreeFour <= next_slotThreeFour;
            heatWhole <= next_heatWhole;
            heatFrac <= next_heatFrac;
            tempBusy <= next_tempBusy;
            tempCnt <= next_tempCnt;
            regRdata <= next_regRdata;
            tempReady <= next_tempReady;
        end
    end

    // ------------------------------------------------------------
    // Sample timing tables
    // ------------------------------------------------------------
    logic [31:0] periodCyc;
    logic [31:0] pulseCyc;
    logic [4:0] resBits;
    logic [17:0] resMask;
    logic [31:0] sps;

    always_comb begin
        unique case (acqSetup[`RATE_HI:`RATE_LO])
            3'h0: sps = `SPS_0;
            3'h1: sps = `SPS_1;
            3'h2: sps = `SPS_2;
            3'h3: sps = `SPS_3;
            3'h4: sps = `SPS_4;
            3'h5: sps = `SPS_5;
            3'h6: sps = `SPS_6;
            3'h7: sps = `SPS_7;
        endcase
        periodCyc = (PERIOD_50_CYC * `SPS_REF) / sps;
        unique case (acqSetup[`PW_HI:`PW_LO])
            2'h0: begin
                pulseCyc = `PW_69_CYC;
                resBits = `RES_PW0;
            end
            2'h1: begin
                pulseCyc = `PW_118_CYC;
                resBits = `RES_PW1;
            end
            2'h2: begin
                pulseCyc = `PW_215_CYC;
                resBits = `RES_PW2;
            end
            2'h3: begin
                pulseCyc = PW_411_CYC;
                resBits = `RES_PW3;
            end
        endcase
        resMask = 18'h3FFFF << (`FULL_BITS - resBits);
    end

    // ------------------------------------------------------------
    // Slot sequencer
    // ------------------------------------------------------------
    seq_state_e seqState;
    seq_state_e next_seqState;
    logic [31:0] periodCnt;
    logic [31:0] next_periodCnt;
    logic [31:0] phaseCnt;
    logic [31:0] next_phaseCnt;
    logic [1:0] slotIdx;
    logic [1:0] next_slotIdx;
    logic [1:0] byteIdx;
    logic [1:0] next_byteIdx;
    logic [17:0] sampleWord;
    logic [17:0] next_sampleWord;
    led_drive_s next_ledDrive;
    logic [2:0] slotCode;
    logic slotActive;
    led_drive_s slotDrive;
    logic tick;
    logic pushValid;
    logic pushReady;
    stream_byte_s pushByte;

    always_comb begin
        if (multiLedMode) begin
            unique case (slotIdx)
                2'h0: slotCode = slotOneTwo[`ODD_SLOT_HI:`ODD_SLOT_LO];
                2'h1: slotCode = slotOneTwo[`EVEN_SLOT_HI:`EVEN_SLOT_LO];
                2'h2: slotCode = slotThreeFour[`ODD_SLOT_HI:`ODD_SLOT_LO];
                2'h3: slotCode = slotThreeFour[`EVEN_SLOT_HI:`EVEN_SLOT_LO];
            endcase
        end else begin
            unique case (slotIdx)
                2'h0: slotCode = `SLOT_RED;
                2'h1: slotCode = `SLOT_IR;
                2'h2: slotCode = `SLOT_GREEN;
                2'h3: slotCode = `SLOT_OFF;
            endcase
        end
    end

    slot_decoder slotDec (
        .code(slotCode),
        .levels(levels),
        .active(slotActive),
        .drive(slotDrive)
    );

    assign tick = acquireEnable && (periodCnt == '0);

    // A period tick that lands while a sample is still being pushed is
    // dropped; save with four active slots at 411 us, the stored rate clamp keeps this from happening unless
    // the receiver stalls for long.
    always_comb begin
        next_seqState = seqState;
        next_slotIdx = slotIdx;
        next_byteIdx = byteIdx;
        next_phaseCnt = phaseCnt;
        next_sampleWord = sampleWord;
        next_periodCnt = periodCnt;
        pushValid = 1'b0;
        pushByte = '0;
        if (!acquireEnable || periodCnt == '0) begin
            next_periodCnt = periodCyc - 32'd1;
        end else begin
            next_periodCnt = periodCnt - 32'd1;
        end
        unique case (seqState)
            SEQ_IDLE: begin
                if (tick) begin
                    next_slotIdx = 2'h0;
                    next_seqState = SEQ_SCAN;
                end
            end
            SEQ_SCAN: begin
                if (slotActive) begin
                    next_phaseCnt = pulseCyc - 32'd1;
                    next_seqState = SEQ_PULSE;
                end else if (slotIdx == 2'h3) begin
                    next_seqState = SEQ_IDLE;
                end else begin
                    next_slotIdx = slotIdx + 2'h1;
                end
            end
            SEQ_PULSE: begin
                if (phaseCnt == '0) begin
                    next_sampleWord = adcSample & resMask;
                    next_byteIdx = 2'h0;
                    next_seqState = SEQ_PUSH;
                end else begin
                    next_phaseCnt = phaseCnt - 32'd1;
                end
            end
            SEQ_PUSH: begin
                pushValid = 1'b1;
                pushByte.slot = slotIdx;
                unique case (byteIdx)
                    2'h0: pushByte.data = {6'h00, sampleWord[17:16]};
                    2'h1: pushByte.data = sampleWord[15:8];
                    default: pushByte.data = sampleWord[7:0];
                endcase
                if (pushReady) begin
                    next_byteIdx = byteIdx + 2'h1;
                    if (byteIdx == 2'h2) begin
                        if (slotIdx == 2'h3) begin
                            next_seqState = SEQ_IDLE;
                        end else begin
                            next_slotIdx = slotIdx + 2'h1;
                            next_seqState = SEQ_SCAN;
                        end
                    end
                end
            end
        endcase
        next_ledDrive = (next_seqState == SEQ_PULSE) ? slotDrive : '0;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seqState <= SEQ_IDLE;
            periodCnt <= '0;
            phaseCnt <= '0;
            slotIdx <= 2'h0;
            byteIdx <= 2'h0;
            sampleWord <= '0;
            ledDrive <= '0;
        end else begin
            seqState <= next_seqState;
            periodCnt <= next_periodCnt;
            phaseCnt <= next_phaseCnt;
            slotIdx <= next_slotIdx;
            byteIdx <= next_byteIdx;
            sampleWord <= next_sampleWord;
            ledDrive <= next_ledDrive;
        end
    end

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    // Two entries let the receiver drop ready for a cycle without the
    // sequencer losing a byte; longer stalls hold the sequencer.
    two_entry_buffer #(
        .WIDTH($bits(stream_byte_s))
    ) outBuf (
        .clk(clk),
        .resetn(resetn),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushByte),
        .outValid(byteValid),
        .outReady(byteReady),
        .outData(byteOut)
    );

endmodule

// >>> core/slot_decoder.sv
`timescale 1ns/1ps
`include "opt_consts.svh"

module slot_decoder import opt_pkg::*; (
    input wire logic [2:0] code,
    input wire led_drive_s levels,
    output logic active,
    output led_drive_s drive
);

    // ------------------------------------------------------------
    // Slot code decode
    // ------------------------------------------------------------
    // Reserved codes are treated like a disabled slot so a bad setting
    // never pushes data nor lights an emitter.
    always_comb begin
        drive = '0;
        active = 1'b0;
        unique case (code)
            `SLOT_RED: begin
                active = 1'b1;
                drive.red = levels.red;
            end
            `SLOT_IR: begin
                active = 1'b1;
                drive.infrared = levels.infrared;
            end
            `SLOT_GREEN: begin
                active = 1'b1;
                drive.greenA = levels.greenA;
                drive.greenB = levels.greenB;
            end
            `SLOT_NONE: begin
                active = 1'b1; // Dark slot, still converted.
            end
            default: begin
                active = 1'b0;
            end
        endcase
    end

endmodule

// >>> core/two_entry_buffer.sv
`timescale 1ns/1ps

module two_entry_buffer #(
    parameter int unsigned WIDTH = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    logic [WIDTH-1:0] skidData;
    logic skidValid;
    logic [WIDTH-1:0] next_outData;
    logic next_outValid;
    logic [WIDTH-1:0] next_skidData;
    logic next_skidValid;
    logic take;

    // Ready depends only on the spare entry, so the source never sees a
    // combinational path from the receiver's ready.
    assign inReady = !skidValid;
    assign take = inValid && inReady;

    // ------------------------------------------------------------
    // Head and spare entry
    // ------------------------------------------------------------
    always_comb begin
        next_outData = outData;
        next_outValid = outValid;
        next_skidData = skidData;
        next_skidValid = skidValid;
        if (outReady || !outValid) begin
            if (skidValid) begin
                next_outData = skidData;
                next_outValid = 1'b1;
                next_skidValid = take;
                next_skidData = inData;
            end else begin
                next_outData = inData;
                next_outValid = take;
            end
        end else if (take) begin
            next_skidData = inData;
            next_skidValid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            outData <= '0;
            outValid <= 1'b0;
            skidData <= '0;
            skidValid <= 1'b0;
        end else begin
            outData <= next_outData;
            outValid <= next_outValid;
            skidData <= next_skidData;
            skidValid <= next_skidValid;
        end
    end

endmodule

// >>> dv/optical_sample_config_temp_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the configuration and temperature block.
// ------------------------------------------------------------
module optical_sample_config_temp_asserts import opt_pkg::*; (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    input wire logic [1:0] converterRange,
    input wire logic byteValid,
    input wire logic byteReady,
    input wire stream_byte_s byteOut,
    input wire logic tempReady
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // A level write followed at once by its read.
    sequence lvl_wr; regWrite && regAddr == 8'h0C; endsequence
    sequence lvl_rd; regRead && regAddr == 8'h0C; endsequence
    AST_LEVEL_RW: assert property (lvl_wr ##1 lvl_rd |=>
        regRdata == $past(regWdata, 2)) else $error("level readback");
    AST_RANGE: assert property (regWrite && regAddr == 8'h0A |=>
        converterRange == $past(regWdata[6:5])) else $error("range");
    AST_UNMAPPED: assert property (regRead && regAddr == 8'h00 |=>
        regRdata == 8'h00) else $error("unmapped read");
    AST_SLOT_GAPS: assert property (regRead &&
        (regAddr == 8'h11 || regAddr == 8'h12) |=>
        (regRdata & 8'h88) == 8'h00) else $error("slot gap bits");
    AST_FRAC_TOP: assert property (regRead && regAddr == 8'h20 |=>
        regRdata[7:4] == 4'h0) else $error("fraction top bits");
    AST_TRIG_TOP: assert property (regRead && regAddr == 8'h21 |=>
        regRdata[7:1] == 7'h00) else $error("trigger top bits");
    AST_TEMP_PULSE: assert property (tempReady |=> !tempReady)
        else $error("ready pulse too long");
    AST_HOLD: assert property (byteValid && !byteReady |=>
        byteValid && $stable(byteOut)) else $error("stalled byte lost");
endmodule

bind optical_sample_config_temp optical_sample_config_temp_asserts
    optical_sample_config_temp_asserts_inst (.clk, .resetn, .regAddr,
    .regWrite, .regWdata, .regRead, .regRdata, .converterRange,
    .byteValid, .byteReady, .byteOut, .tempReady);

// >>> dv/sensor_sink_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Analog front end and stream receiver seen by the block.
// ------------------------------------------------------------
module sensor_sink_model (
    input wire logic clk,
    input wire logic resetn,
    output logic byteReady,
    output logic [17:0] adcSample,
    output logic [11:0] tempSense
);
    // Fixed readings, so every expectation is known ahead.
    assign adcSample = 18'h2A5C3;
    assign tempSense = 12'hF38;
    // The receiver stalls every other cycle to exercise the buffer.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            byteReady <= 1'b0;
        end else begin
            byteReady <= !byteReady;
        end
    end
endmodule

// >>> dv/tb_optical_sample_config_temp.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench.
// ------------------------------------------------------------
module tb_optical_sample_config_temp import opt_pkg::*;;
    logic clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rd;
    logic acquireEnable = 1'b0, multiLedMode = 1'b0, byteValid, byteReady;
    logic [17:0] adcSample;
    logic [11:0] tempSense;
    logic [1:0] converterRange;
    logic tempReady;
    led_drive_s ledDrive, firstDrive = '0, greenDrive = '0;
    stream_byte_s byteOut, got[$];
    int errors = 0, n_checks = 0;
    always #50 clk = !clk;
    optical_sample_config_temp #(.PERIOD_50_CYC(4000), .PW_411_CYC(40),
        .TEMP_CONV_CYC(20)) optical_sample_config_temp_inst (.clk, .resetn,
        .regAddr, .regWrite, .regWdata, .regRead, .regRdata, .acquireEnable,
        .multiLedMode, .adcSample, .tempSense, .converterRange, .ledDrive,
        .byteValid, .byteReady, .byteOut, .tempReady);
    sensor_sink_model sensor_sink_model_inst (.clk, .resetn, .byteReady,
        .adcSample, .tempSense);
    // Record every accepted byte, the first drive and a green drive.
    always @(posedge clk) begin
        if (byteValid && byteReady) got.push_back(byteOut);
        if (ledDrive != '0 && firstDrive == '0) firstDrive <= ledDrive;
        if (ledDrive.greenA != '0) greenDrive <= ledDrive;
    end
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        regRead <= 1'b1; regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check("register", regRdata, exp);
    endtask
    // Every register starts at zero; the gap address reads zero too.
    task automatic t_reset();
        logic [7:0] adr[11] = '{8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h11,
            8'h12, 8'h1F, 8'h20, 8'h21, 8'h00};
        foreach (adr[i]) rdc(adr[i], 8'h00);
    endtask
    // Levels, slot masking and the rate clamp.
    task automatic t_regs();
        // Write then read the red level on back-to-back edges.
        @(posedge clk);
        regWrite <= 1'b1; regAddr <= 8'h0C; regWdata <= 8'h55;
        @(posedge clk);
        regWrite <= 1'b0; regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check("level", regRdata, 8'h55);
        wr(8'h0F, 8'hFF);
        rdc(8'h0F, 8'hFF);
        wr(8'h12, 8'hFF);
        rdc(8'h12, 8'h77);
        wr(8'h12, 8'h00);
        wr(8'h0A, 8'h5F);
        rdc(8'h0A, 8'h53);
        check("range", {6'h00, converterRange}, 8'h02);
    endtask
    // One temperature conversion, waited for on the ready flag.
    task automatic t_temp();
        wr(8'h21, 8'h01);
        rdc(8'h21, 8'h01);
        for (int i = 0; i < 100 && !tempReady; i++) @(posedge clk);
        check("ready", {7'h00, tempReady}, 8'h01);
        // Whole and fraction are always read as a pair.
        rdc(8'h21, 8'h00);
        rdc(8'h1F, 8'hF3);
        rdc(8'h20, 8'h08);
    endtask
    // Four contiguous slots, the last one dark, then the fixed order.
    task automatic t_stream();
        logic [7:0] exp[3] = '{8'h02, 8'hA5, 8'hC3};
        wr(8'h0C, 8'h10);
        wr(8'h0D, 8'h20);
        wr(8'h0E, 8'h30);
        wr(8'h11, 8'h21);
        wr(8'h12, 8'h43);
        wr(8'h0A, 8'h43);
        multiLedMode <= 1'b1;
        acquireEnable <= 1'b1;
        for (int i = 0; i < 12000 && got.size() < 12; i++) @(posedge clk);
        check("count", 8'(got.size()), 8'h0C);
        for (int i = 0; i < 12 && i < got.size(); i++) begin
            check("data", got[i].data, exp[i % 3]);
            check("slot", {6'h00, got[i].slot}, 8'(i / 3));
        end
        check("red", firstDrive.red, 8'h10);
        check("ir", firstDrive.infrared, 8'h00);
        check("green a", greenDrive.greenA, 8'h30);
        check("green b", greenDrive.greenB, 8'hFF);
        // Without slot fields, red, infrared and green fire in turn.
        multiLedMode <= 1'b0;
        for (int i = 0; i < 12000 && got.size() < 21; i++) @(posedge clk);
        check("count", 8'(got.size()), 8'h15);
        for (int i = 12; i < 21 && i < got.size(); i++) begin
            check("data", got[i].data, exp[i % 3]);
            check("slot", {6'h00, got[i].slot}, 8'((i - 12) / 3));
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_temp();
        t_stream();
        tally_and_finish();
    end
    // A hang counts as a failure and ends the run the same way.
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule
